/* mmrro_pkg.sv */
// Shared constants, types and helpers for the move, return and rotate execution block
package mmrro_pkg;

	// Widths of the datapath
	localparam int FILE_ADDR_W = 6;
	localparam int PC_W        = 10;
	localparam int LEVEL_W     = 4;
	localparam int STACK_DEPTH = 8;
	localparam int FILE_DEPTH  = 64;

	// APB byte offsets of the control registers
	localparam logic [11:0] OFF_CMD       = 12'h000;
	localparam logic [11:0] OFF_WORK      = 12'h004;
	localparam logic [11:0] OFF_STATUS    = 12'h008;
	localparam logic [11:0] OFF_PC        = 12'h00C;
	localparam logic [11:0] OFF_PUSH      = 12'h010;
	localparam logic [11:0] OFF_TOP       = 12'h014;
	// File registers occupy one word each within this page only
	localparam logic [3:0]  FILE_PAGE     = 4'h1;

	// Command word fields
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_DIR_BIT  = 4;
	localparam int CMD_ADDR_LSB = 5;
	localparam int CMD_IMM_LSB  = 16;

	// Status register bit positions
	localparam int ST_CARRY_BIT = 0;
	localparam int ST_ZERO_BIT  = 1;
	localparam int ST_GIE_BIT   = 2;

	// Opcodes carried in the command word
	localparam logic [3:0] OP_NOP   = 4'h0;
	localparam logic [3:0] OP_STORE = 4'h1;
	localparam logic [3:0] OP_LDI   = 4'h2;
	localparam logic [3:0] OP_COPY  = 4'h3;
	localparam logic [3:0] OP_RETURN_IRQ_REENABLE = 4'h4;
	localparam logic [3:0] OP_RETLI = 4'h5;
	localparam logic [3:0] OP_ROTL  = 4'h6;

	// Values after reset
	localparam logic [7:0]         RST_WORK  = 8'h00;
	localparam logic [PC_W-1:0]    RST_PC    = 10'h000;
	localparam logic [7:0]         RST_FILE  = 8'h00;
	localparam logic [LEVEL_W-1:0] RST_LEVEL = 4'h0;

	// Sequencer states
	typedef enum {ST_IDLE, ST_RUN, ST_WAIT2, ST_DONE} mmrro_state_t;

	// Rotate left through carry: result in [7:0], carry out in [8]
	function automatic logic [8:0] mmrro_rotl(input logic [7:0] v, input logic c);
		return {v[7], v[6:0], c};
	endfunction : mmrro_rotl

endpackage : mmrro_pkg

/* mmrro_file_regs.sv */
// Sixty-four byte file register space with one write and two read ports
`timescale 1ns/1ns
module mmrro_file_regs
	import mmrro_pkg::*;
(
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   reset,
	// Write port
	input  wire logic                   wr_en,
	input  wire logic [FILE_ADDR_W-1:0] wr_addr,
	input  wire logic [7:0]             wr_data,
	// Read port for the bus
	input  wire logic [FILE_ADDR_W-1:0] rd_a_addr,
	output      logic [7:0]             rd_a_data,
	// Read port for execution
	input  wire logic [FILE_ADDR_W-1:0] rd_b_addr,
	output      logic [7:0]             rd_b_data
);

	// Storage array
	logic [7:0] mem_r [FILE_DEPTH];

	// Reads are asynchronous so an operand is ready in the execute cycle
	assign rd_a_data = mem_r[rd_a_addr];
	assign rd_b_data = mem_r[rd_b_addr];

	// Single write port, cleared on reset
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < FILE_DEPTH; i++) begin
				mem_r[i] <= RST_FILE;
			end
		end else if (wr_en) begin
			mem_r[wr_addr] <= wr_data;
		end
	end

endmodule : mmrro_file_regs

/* mmrro_stack.sv */
// Return address stack indexed by its level, entry one at the bottom
`timescale 1ns/1ns
module mmrro_stack
	import mmrro_pkg::*;
(
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               reset,
	// Control
	input  wire logic               push,
	input  wire logic               pop,
	input  wire logic [PC_W-1:0]    push_data,
	// State
	output      logic [PC_W-1:0]    top,
	output      logic [LEVEL_W-1:0] level,
	output      logic               full
);

	// Entries and level
	logic [PC_W-1:0]    mem_r [1:STACK_DEPTH];
	logic [LEVEL_W-1:0] level_r;
	logic [LEVEL_W-1:0] level_nxt;
	logic               empty;

	assign empty = (level_r == RST_LEVEL);
	assign full  = (level_r == LEVEL_W'(STACK_DEPTH));
	assign level = level_r;
	// Empty stack reads as address zero
	assign top   = empty ? RST_PC : mem_r[level_r];

	// Push beyond the top and pop below the bottom are both ignored
	assign level_nxt = (push && !full)  ? level_r + 4'h1 :
	                   (pop  && !empty) ? level_r - 4'h1 : level_r;

	// Level register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			level_r <= RST_LEVEL;
		end else begin
			level_r <= level_nxt;
		end
	end

	// Entry write on push
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 1; i <= STACK_DEPTH; i++) begin
				mem_r[i] <= RST_PC;
			end
		end else if (push && !full) begin
			mem_r[level_r + 4'h1] <= push_data;
		end
	end

endmodule : mmrro_stack

/* mmrro_core.sv */
// Executes moves, returns and rotate-left on commands written over APB
//
// Functional notes
// - Store work register into selected file register
// - Load immediate byte into work register
// - No-op changes nothing, program counter advances
// - Copy file register to work or itself
// - Copy sets zero flag from moved value
// - Return pops counter, sets interrupt enable, two cycles
// - Every return lowers stack level by one, except at level zero where it stays
// - Return with immediate loads work, sets enable
// - Rotate left through carry, only carry changes
// - Rotate result goes to work or file
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
module mmrro_core
	import mmrro_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset,
	// APB slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	// Core state for observation
	output      logic [7:0]  work_out,
	output      logic        global_irq_enable,
	output      logic [9:0]  pc_out
);

	// Sequencer
	mmrro_state_t state_r;
	mmrro_state_t state_nxt;

	// Architectural registers
	logic [7:0]      work_r;
	logic [7:0]      work_nxt;
	logic            carry_r;
	logic            carry_nxt;
	logic            zero_r;
	logic            zero_nxt;
	logic            gie_r;
	logic            gie_nxt;
	logic [PC_W-1:0] pc_r;
	logic [PC_W-1:0] pc_nxt;
	logic [31:0]     prdata_r;
	logic [31:0]     prdata_nxt;

	// Bus decode
	logic access;
	logic sel_cmd;
	logic sel_work;
	logic sel_status;
	logic sel_pc;
	logic sel_push;
	logic sel_top;
	logic sel_file;
	logic mapped;
	logic done;
	logic bus_wr;
	logic bus_err;

	// Command fields, held stable by the master through the access phase
	logic [3:0]             op;
	logic                   dir;
	logic [FILE_ADDR_W-1:0] faddr;
	logic [7:0]             imm;
	logic                   op_valid;
	logic                   cmd_ok;
	logic                   run;
	logic                   is_ret;

	// Execution datapath
	logic [7:0]             fr_x;
	logic [7:0]             fr_bus;
	logic [8:0]             rot;
	logic                   fw_en;
	logic [FILE_ADDR_W-1:0] fw_addr;
	logic [7:0]             fw_data;
	logic                   exec_fw;

	// Stack connections
	logic            stk_push;
	logic            stk_pop;
	logic [PC_W-1:0] stk_top;
	logic [3:0]      stk_level;
	logic            stk_full;

	// Address decode, file registers fill the whole page
	assign access     = psel && penable;
	assign sel_cmd    = (paddr == OFF_CMD);
	assign sel_work   = (paddr == OFF_WORK);
	assign sel_status = (paddr == OFF_STATUS);
	assign sel_pc     = (paddr == OFF_PC);
	assign sel_push   = (paddr == OFF_PUSH);
	assign sel_top    = (paddr == OFF_TOP);
	assign sel_file   = (paddr[11:8] == FILE_PAGE) && (paddr[1:0] == 2'h0);
	assign mapped     = sel_cmd || sel_work || sel_status || sel_pc ||
	                    sel_push || sel_top || sel_file;

	// Plain register writes land on the completing edge only
	assign done   = (state_r == ST_DONE);
	assign bus_wr = done && access && pwrite;

	// Command decode
	assign op       = pwdata[CMD_OP_LSB +: 4];
	assign dir      = pwdata[CMD_DIR_BIT];
	assign faddr    = pwdata[CMD_ADDR_LSB +: FILE_ADDR_W];
	assign imm      = pwdata[CMD_IMM_LSB +: 8];
	assign op_valid = (op <= OP_ROTL);
	// A partial command word would run a half-written instruction
	assign cmd_ok   = (pstrb[2:0] == 3'h7) && op_valid;
	assign run      = (state_r == ST_RUN);
	assign is_ret   = (op == OP_RETURN_IRQ_REENABLE) || (op == OP_RETLI);

	// Error answer for unmapped, malformed or overflowing accesses
	assign bus_err = !mapped || (sel_cmd && pwrite && !cmd_ok) ||
	                 (sel_push && pwrite && stk_full);

	// Handshake outputs
	assign pready  = done;
	assign pslverr = done && bus_err;
	assign prdata  = prdata_r;

	// Observation outputs
	assign work_out          = work_r;
	assign global_irq_enable = gie_r;
	assign pc_out            = pc_r;

	assign rot = mmrro_rotl(fr_x, carry_r);

	// copy writes back to itself when dir is one
	// rotate writes file when dir is one
	assign exec_fw = run && ((op == OP_STORE) ||
	                         ((op == OP_COPY) && dir) ||
	                         ((op == OP_ROTL) && dir));
	assign fw_en   = exec_fw || (bus_wr && sel_file && pstrb[0]);
	assign fw_addr = run ? faddr : paddr[7:2];
	assign fw_data = !run              ? pwdata[7:0] :
	                 (op == OP_STORE)  ? work_r :
	                 (op == OP_COPY)   ? fr_x : rot[7:0];

	// each return pops the stack once, unless the stack is already empty
	assign stk_pop  = run && is_ret;
	assign stk_push = bus_wr && sel_push && (pstrb[1:0] == 2'h3);

	// copy into work when dir is zero
	// rotate into work when dir is zero
	assign work_nxt = (run && ((op == OP_LDI) || (op == OP_RETLI))) ? imm :
	                  (run && (op == OP_COPY) && !dir)              ? fr_x :
	                  (run && (op == OP_ROTL) && !dir)              ? rot[7:0] :
	                  (bus_wr && sel_work && pstrb[0])              ? pwdata[7:0] :
	                  work_r;

	assign carry_nxt = (run && (op == OP_ROTL))             ? rot[8] :
	                   (bus_wr && sel_status && pstrb[0])   ? pwdata[ST_CARRY_BIT] :
	                   carry_r;

	// zero flag follows the moved value
	assign zero_nxt = (run && (op == OP_COPY))            ? (fr_x == 8'h00) :
	                  (bus_wr && sel_status && pstrb[0])  ? pwdata[ST_ZERO_BIT] :
	                  zero_r;

	assign gie_nxt = (run && is_ret)                     ? 1'b1 :
	                 (bus_wr && sel_status && pstrb[0])  ? pwdata[ST_GIE_BIT] :
	                 gie_r;

	// counter advances by one for non-returns
	assign pc_nxt = (run && is_ret)                          ? stk_top :
	                run                                      ? pc_r + 10'h001 :
	                (bus_wr && sel_pc && (pstrb[1:0] == 2'h3)) ? pwdata[PC_W-1:0] :
	                pc_r;

	// Read mux, captured one cycle before the answer
	assign prdata_nxt = sel_work   ? {24'h000000, work_r} :
	                    sel_status ? {29'h0000000, gie_r, zero_r, carry_r} :
	                    sel_pc     ? {22'h00000, pc_r} :
	                    sel_push   ? {28'h0000000, stk_level} :
	                    sel_top    ? {22'h00000, stk_top} :
	                    sel_file   ? {24'h000000, fr_bus} : 32'h00000000;

	// Sequencer next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			// Wait for an access phase
			ST_IDLE: begin
				if (access) begin
					state_nxt = (pwrite && sel_cmd && cmd_ok) ? ST_RUN : ST_DONE;
				end
			end
			ST_RUN: begin
				state_nxt = is_ret ? ST_WAIT2 : ST_DONE;
			end
			// Second cycle of a return
			ST_WAIT2: begin
				state_nxt = ST_DONE;
			end
			// Answer cycle
			ST_DONE: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// registers only move through their next-value terms
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_r <= ST_IDLE;
			work_r  <= RST_WORK;
			carry_r <= 1'b0;
			zero_r  <= 1'b0;
			gie_r   <= 1'b0;
			pc_r    <= RST_PC;
		end else begin
			state_r <= state_nxt;
			work_r  <= work_nxt;
			carry_r <= carry_nxt;
			zero_r  <= zero_nxt;
			gie_r   <= gie_nxt;
			pc_r    <= pc_nxt;
		end
	end

	// Read data register, loaded as a plain access is accepted
	always_ff @(posedge core_clk) begin
		if (reset) begin
			prdata_r <= 32'h00000000;
		end else if (state_r == ST_IDLE && access) begin
			prdata_r <= pwrite ? 32'h00000000 : prdata_nxt;
		end
	end

	// File register space
	mmrro_file_regs u_file (
		.core_clk  (core_clk),
		.reset     (reset),
		.wr_en     (fw_en),
		.wr_addr   (fw_addr),
		.wr_data   (fw_data),
		.rd_a_addr (paddr[7:2]),
		.rd_a_data (fr_bus),
		.rd_b_addr (faddr),
		.rd_b_data (fr_x)
	);

	// Return address stack
	mmrro_stack u_stack (
		.core_clk  (core_clk),
		.reset     (reset),
		.push      (stk_push),
		.pop       (stk_pop),
		.push_data (pwdata[PC_W-1:0]),
		.top       (stk_top),
		.level     (stk_level),
		.full      (stk_full)
	);

	// Checks on execution results
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	chk_store_file: assert property (
		run && op == OP_STORE |=> fr_x == $past(work_r) && $stable(work_r)
	) else $error("store did not copy work register");

	chk_ldi_work: assert property (
		run && op == OP_LDI |=> work_r == $past(imm) && $stable(carry_r) && $stable(zero_r)
	) else $error("immediate load wrong");

	chk_nop_still: assert property (
		run && op == OP_NOP |=> $stable(work_r) && $stable(carry_r) && $stable(zero_r)
		&& $stable(gie_r) && pc_r == $past(pc_r) + 10'h001
	) else $error("no-op changed state");

	chk_copy_dest: assert property (
		run && op == OP_COPY && !dir |=> work_r == $past(fr_x)
	) else $error("copy to work wrong");

	chk_copy_zero: assert property (
		run && op == OP_COPY |=> zero_r == ($past(fr_x) == 8'h00) && $stable(carry_r)
	) else $error("zero flag wrong after copy");

	chk_return_irq_reenable_pop: assert property (
		run && op == OP_RETURN_IRQ_REENABLE |=> gie_r && pc_r == $past(stk_top) ##1 done
	) else $error("return did not reload counter in two cycles");

	chk_ret_level: assert property (
		run && is_ret && stk_level != 4'h0 |=> stk_level == $past(stk_level) - 4'h1
	) else $error("stack level not lowered");

	chk_retli_work: assert property (
		run && op == OP_RETLI |=> work_r == $past(imm) && gie_r && $stable(carry_r)
	) else $error("return with immediate wrong");

	chk_rotl_value: assert property (
		run && op == OP_ROTL |=> carry_r == $past(fr_x[7]) && $stable(zero_r)
	) else $error("rotate carry wrong");

	chk_rotl_dest: assert property (
		run && op == OP_ROTL |=> (dir ? fr_x : work_r) == {$past(fr_x[6:0]), $past(carry_r)}
	) else $error("rotate result wrong");

	chk_flags_kept: assert property (
		run && (op == OP_STORE || op == OP_RETURN_IRQ_REENABLE) |=> $stable(carry_r) && $stable(zero_r)
		&& $stable(work_r)
	) else $error("untouched state changed");

	chk_gie_kept: assert property (
		run && !is_ret |=> $stable(gie_r)
	) else $error("global enable changed by a non-return");

	chk_retli_pc: assert property (
		run && op == OP_RETLI |=> pc_r == $past(stk_top) ##1 done
	) else $error("return with immediate did not reload counter");

	chk_refused_still: assert property (
		done && pslverr |-> $stable(work_r) && $stable(pc_r) && $stable(carry_r)
	) else $error("refused access changed state");

	// Main scenarios
	cov_return_irq_reenable:     cover property (run && op == OP_RETURN_IRQ_REENABLE);
	cov_rotl_file: cover property (run && op == OP_ROTL && dir);
	cov_copy_zero: cover property (run && op == OP_COPY && fr_x == 8'h00);
	cov_bus_err:   cover property (pslverr);
	cov_push_full: cover property (sel_push && stk_full && pslverr);

endmodule : mmrro_core

/* mcu_move_return_rotate_ops_bench.sv */
// Self-checking bench for the move, return and rotate execution block
`timescale 1ns/1ns
module mcu_move_return_rotate_ops_bench;
	import mmrro_pkg::*;

	// Clock and reset
	logic        core_clk;
	logic        reset;
	// APB master side
	logic [11:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	// Observed core state
	logic [7:0]  work_out;
	logic        global_irq_enable;
	logic [9:0]  pc_out;
	// Bench bookkeeping
	int          n_errors;
	int          num_checks;
	int          cycles;
	logic [31:0] rd;
	logic        err;
	int          acc;

	// Device under test
	mmrro_core i_dut (
		.core_clk          (core_clk),
		.reset             (reset),
		.paddr             (paddr),
		.psel              (psel),
		.penable           (penable),
		.pwrite            (pwrite),
		.pwdata            (pwdata),
		.pstrb             (pstrb),
		.prdata            (prdata),
		.pready            (pready),
		.pslverr           (pslverr),
		.work_out          (work_out),
		.global_irq_enable (global_irq_enable),
		.pc_out            (pc_out)
	);

	// Free-running 20 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// Hang guard, well above the length of the sequence
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors = n_errors + 1;
			end_of_test();
		end
	end

	// Verdict and end of run
	task automatic end_of_test();
		$display("Checks %0d, errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	// Compare seen against expected, four-state exact
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		num_checks = num_checks + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		acc = 0;
		do begin
			@(posedge core_clk);
			acc = acc + 1;
		end while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Read a register and compare its value
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0000_0000);
		check(rd, exp, what);
	endtask : rdchk

	// Command word built from its fields
	function automatic logic [31:0] cmd(input logic [3:0] op, input logic dir,
			input logic [5:0] fa, input logic [7:0] imm);
		return {8'h00, imm, 5'h00, fa, dir, op};
	endfunction : cmd

	// Byte address of file register n
	function automatic logic [11:0] faddr(input logic [5:0] n);
		return {FILE_PAGE, n, 2'b00};
	endfunction : faddr

	// Main sequence
	initial begin
		reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0000_0000; pstrb = 4'hF;
		n_errors = 0; num_checks = 0; cycles = 0;
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		// Reset state
		rdchk(OFF_WORK, 32'h0000_0000, "work reset");
		rdchk(OFF_STATUS, 32'h0000_0000, "status reset");
		rdchk(OFF_PC, 32'h0000_0000, "pc reset");
		rdchk(OFF_PUSH, 32'h0000_0000, "level reset");
		// Immediate load with carry and zero preset
		apb(1'b1, OFF_STATUS, 32'h0000_0003);
		apb(1'b1, OFF_CMD, cmd(OP_LDI, 1'b0, 6'h00, 8'hA5));
		check(acc, 3, "ldi length");
		rdchk(OFF_WORK, 32'h0000_00A5, "ldi work");
		rdchk(OFF_STATUS, 32'h0000_0003, "ldi flags");
		rdchk(OFF_PC, 32'h0000_0001, "ldi pc");
		// Store to top file register
		apb(1'b1, OFF_CMD, cmd(OP_STORE, 1'b0, 6'h3F, 8'h00));
		check(acc, 3, "store length");
		rdchk(faddr(6'h3F), 32'h0000_00A5, "store file");
		rdchk(faddr(6'h3E), 32'h0000_0000, "store neighbour");
		rdchk(OFF_STATUS, 32'h0000_0003, "store flags");
		// No-op, then pc wrap at ten bits
		apb(1'b1, OFF_CMD, cmd(OP_NOP, 1'b0, 6'h00, 8'h00));
		check(acc, 3, "nop length");
		check(pc_out, 32'h0000_0003, "nop pc");
		check(work_out, 32'h0000_00A5, "nop work");
		rdchk(OFF_STATUS, 32'h0000_0003, "nop flags");
		apb(1'b1, OFF_PC, 32'h0000_03FF);
		apb(1'b1, OFF_CMD, cmd(OP_NOP, 1'b0, 6'h00, 8'h00));
		rdchk(OFF_PC, 32'h0000_0000, "nop wrap");
		// Copy a zero to work, then test a non-zero in place
		apb(1'b1, OFF_STATUS, 32'h0000_0001);
		apb(1'b1, OFF_CMD, cmd(OP_COPY, 1'b0, 6'h3E, 8'h00));
		rdchk(OFF_WORK, 32'h0000_0000, "copy work");
		rdchk(OFF_STATUS, 32'h0000_0003, "copy zero set");
		apb(1'b1, OFF_CMD, cmd(OP_COPY, 1'b1, 6'h3F, 8'h00));
		rdchk(faddr(6'h3F), 32'h0000_00A5, "copy in place");
		rdchk(OFF_WORK, 32'h0000_0000, "copy work kept");
		rdchk(OFF_STATUS, 32'h0000_0001, "copy zero clear");
		// Rotate into the file, then into work
		apb(1'b1, OFF_STATUS, 32'h0000_0002);
		apb(1'b1, OFF_CMD, cmd(OP_ROTL, 1'b1, 6'h3F, 8'h00));
		rdchk(faddr(6'h3F), 32'h0000_004A, "rotl file");
		rdchk(OFF_STATUS, 32'h0000_0003, "rotl carry out");
		rdchk(OFF_WORK, 32'h0000_0000, "rotl work kept");
		apb(1'b1, OFF_CMD, cmd(OP_ROTL, 1'b0, 6'h3F, 8'h00));
		rdchk(OFF_WORK, 32'h0000_0095, "rotl work");
		rdchk(faddr(6'h3F), 32'h0000_004A, "rotl file kept");
		rdchk(OFF_STATUS, 32'h0000_0002, "rotl carry in");
		// Return with interrupt enable from level two
		apb(1'b1, OFF_STATUS, 32'h0000_0000);
		apb(1'b1, OFF_PUSH, 32'h0000_0123);
		apb(1'b1, OFF_PUSH, 32'h0000_02AB);
		rdchk(OFF_PUSH, 32'h0000_0002, "level two");
		apb(1'b1, OFF_CMD, cmd(OP_RETURN_IRQ_REENABLE, 1'b0, 6'h00, 8'h00));
		check(acc, 4, "return_irq_reenable length");
		check(global_irq_enable, 1'b1, "return_irq_reenable enable");
		rdchk(OFF_PC, 32'h0000_02AB, "return_irq_reenable pc");
		rdchk(OFF_PUSH, 32'h0000_0001, "return_irq_reenable level");
		rdchk(OFF_TOP, 32'h0000_0123, "return_irq_reenable top");
		rdchk(OFF_WORK, 32'h0000_0095, "return_irq_reenable work");
		// Return with immediate from level one
		apb(1'b1, OFF_STATUS, 32'h0000_0001);
		apb(1'b1, OFF_CMD, cmd(OP_RETLI, 1'b0, 6'h00, 8'h3C));
		rdchk(OFF_WORK, 32'h0000_003C, "retli work");
		rdchk(OFF_PC, 32'h0000_0123, "retli pc");
		rdchk(OFF_STATUS, 32'h0000_0005, "retli flags");
		rdchk(OFF_PUSH, 32'h0000_0000, "retli level");
		// Refused opcode and unmapped address
		apb(1'b1, OFF_CMD, cmd(4'h7, 1'b0, 6'h00, 8'h11));
		check(err, 1'b1, "bad opcode");
		rdchk(OFF_WORK, 32'h0000_003C, "bad opcode work");
		apb(1'b0, 12'h0FC, 32'h0000_0000);
		check(err, 1'b1, "unmapped");
		// Half-written command is refused and not run
		pstrb <= 4'h3;
		apb(1'b1, OFF_CMD, cmd(OP_LDI, 1'b0, 6'h00, 8'h77));
		check(err, 1'b1, "half command");
		pstrb <= 4'hF;
		rdchk(OFF_WORK, 32'h0000_003C, "half command work");
		// Push beyond a full stack is refused
		repeat (8) apb(1'b1, OFF_PUSH, 32'h0000_0155);
		apb(1'b1, OFF_PUSH, 32'h0000_0266);
		check(err, 1'b1, "push when full");
		rdchk(OFF_PUSH, 32'h0000_0008, "level at full");
		rdchk(OFF_TOP, 32'h0000_0155, "top kept when full");
		end_of_test();
	end

endmodule : mcu_move_return_rotate_ops_bench
